// ==== logic/sli_pkg.sv ====
// Constants, register map and timing counts for the status lamp block.
package sli_pkg;

   // Bus geometry.
   localparam int          SLI_ADDR_W     = 4;
   localparam int          SLI_DATA_W     = 32;

   // Register byte offsets.
   localparam logic [3:0]  SLI_OFF_CTRL   = 4'h0;
   localparam logic [3:0]  SLI_OFF_LAMP   = 4'h4;
   localparam logic [3:0]  SLI_OFF_IRQ_ST = 4'h8;
   localparam logic [3:0]  SLI_OFF_IRQ_MK = 4'hc;

   // Control register fields.
   localparam int          SLI_CTRL_BANK_LO = 0;
   localparam int          SLI_CTRL_UNLOCK  = 2;
   localparam logic [1:0]  SLI_CTRL_BANK_RST = 2'h0;
   localparam logic        SLI_CTRL_UNLOCK_RST = 1'b0;

   // Status (interrupt) bits.
   localparam int          SLI_IRQ_W       = 3;
   localparam int          SLI_IRQ_OK_CHG  = 0;
   localparam int          SLI_IRQ_REF_CHG = 1;
   localparam int          SLI_IRQ_STD_CHG = 2;
   localparam logic [2:0]  SLI_IRQ_MK_RST  = 3'h0;

   // Number of lamps.
   localparam int          SLI_LAMPS = 10;

   // Flash timing: half period in ms, cycles at 100 MHz.
   localparam int          SLI_CLK_HZ        = 100_000_000;
   localparam int          SLI_FLASH_HALF_MS = 333;
   localparam int          SLI_FLASH_HALF_CYC = SLI_CLK_HZ / 1000 * SLI_FLASH_HALF_MS;

   // Menu bank selections.
   typedef enum logic [1:0]
   {
      SLI_BANK_A = 2'h0,
      SLI_BANK_B = 2'h1,
      SLI_BANK_C = 2'h2
   } sli_bank_t;

   // Timing modes.
   typedef enum logic [1:0]
   {
      SLI_TM_FREE  = 2'h0,
      SLI_TM_LINE  = 2'h1,
      SLI_TM_FRAME = 2'h2
   } sli_tmode_t;

   // Raster standard codes.
   localparam logic [1:0]  SLI_STD_NONE = 2'h0;
   localparam logic [1:0]  SLI_STD_525  = 2'h1;
   localparam logic [1:0]  SLI_STD_625  = 2'h2;

endpackage : sli_pkg

// ==== logic/sli_flash_div.sv ====
// Divider that produces the equal-duty flashing phase for lamps.
`timescale 1ns/1ps
`default_nettype none
module sli_flash_div
   import sli_pkg::*;
#(
   parameter int HALF_CYC = SLI_FLASH_HALF_CYC
)
(
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   output logic      phase_o
);

   logic [26:0] cnt_r;
   logic        phase_r;
   wire         wrap = (cnt_r == 27'(HALF_CYC - 1));

   // A toggle every half period gives equal on and off time.
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         cnt_r   <= 27'h0;
         phase_r <= 1'b0;
      end
      else if (wrap)
      begin
         cnt_r   <= 27'h0;
         phase_r <= ~phase_r;
      end
      else
      begin
         cnt_r <= cnt_r + 27'h1;
      end
   end

   assign phase_o = phase_r;

endmodule : sli_flash_div
`default_nettype wire

// ==== logic/sli_lamps.sv ====
// Status lamp driver with an Avalon-MM register slave and interrupt.
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sli_lamps
   import sli_pkg::*;
#(
   parameter int FLASH_HALF_CYC = SLI_FLASH_HALF_CYC
)
(
   input  wire logic                  clk_i,
   input  wire logic                  reset_n_i,
   // Avalon-MM slave.
   input  wire logic [SLI_ADDR_W-1:0] avs_address_i,
   input  wire logic                  avs_read_i,
   input  wire logic                  avs_write_i,
   input  wire logic [SLI_DATA_W-1:0] avs_writedata_i,
   output logic      [SLI_DATA_W-1:0] avs_readdata_o,
   output logic                       avs_waitrequest_o,
   // Status from the decoder core.
   input  wire logic                  input_valid_i,
   input  wire logic [1:0]            input_std_i,
   input  wire logic [1:0]            timing_mode_i,
   input  wire logic                  ref_frame_present_i,
   input  wire logic                  ref_bnc_present_i,
   input  wire logic                  ref_locked_i,
   input  wire logic [1:0]            ref_std_i,
   input  wire logic                  freeze_any_i,
   // Lamps.
   output logic                       lamp_input_ok_o,
   output logic                       lamp_error_o,
   output logic                       lamp_bank_a_o,
   output logic                       lamp_bank_b_o,
   output logic                       lamp_bank_c_o,
   output logic                       lamp_in525_o,
   output logic                       lamp_in625_o,
   output logic                       lamp_ref_ok_o,
   output logic                       lamp_freeze_o,
   output logic                       lamp_access_o,
   output logic                       irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Control registers written by the menu software, and the bus acknowledge flop.

   sli_bank_t             bank_r;
   logic                  unlock_r;
   logic [SLI_IRQ_W-1:0]  irq_st_r;
   logic [SLI_IRQ_W-1:0]  irq_mk_r;
   logic                  ack_r;

   ////////////////////////////////////////////////////////////////////////////
   // Status decode.

   function automatic logic std_match(input logic [1:0] a, input logic [1:0] b);
      return (a == b) && (a != SLI_STD_NONE);
   endfunction : std_match

   wire ref_present  = ref_frame_present_i | ref_bnc_present_i;
   wire ref_needed   = (timing_mode_i == SLI_TM_LINE)
                     | (timing_mode_i == SLI_TM_FRAME);
   wire ref_match    = std_match(ref_std_i, input_std_i);
   wire ref_good     = ref_present & ref_locked_i & ref_match;
   wire ok_nxt       = input_valid_i & (~ref_needed | ref_good);
   wire flash_phase;

   logic [9:0] lamp_nxt;
   always_comb
   begin
      lamp_nxt    = 10'h0;
      lamp_nxt[0] = ok_nxt;
      lamp_nxt[1] = ~ok_nxt;
      lamp_nxt[2] = (bank_r == SLI_BANK_A);
      lamp_nxt[3] = (bank_r == SLI_BANK_B);
      lamp_nxt[4] = (bank_r == SLI_BANK_C);
      lamp_nxt[5] = (input_std_i == SLI_STD_525);
      lamp_nxt[6] = (input_std_i == SLI_STD_625);
      if (!ref_present)
         lamp_nxt[7] = 1'b0;
      else if (ref_match)
         lamp_nxt[7] = ref_locked_i;
      else
         lamp_nxt[7] = flash_phase;
      lamp_nxt[8] = freeze_any_i;
      lamp_nxt[9] = unlock_r;
   end

   sli_flash_div #(
      .HALF_CYC (FLASH_HALF_CYC)
   ) u_flash (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .phase_o   (flash_phase)
   );

   // Lamps come from flip-flops so they never glitch at the card edge.
   logic [SLI_LAMPS-1:0] lamp_r;
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         lamp_r <= 10'h4;
      else
         lamp_r <= lamp_nxt;
   end

   assign lamp_input_ok_o = lamp_r[0];
   assign lamp_error_o    = lamp_r[1];
   assign lamp_bank_a_o   = lamp_r[2];
   assign lamp_bank_b_o   = lamp_r[3];
   assign lamp_bank_c_o   = lamp_r[4];
   assign lamp_in525_o    = lamp_r[5];
   assign lamp_in625_o    = lamp_r[6];
   assign lamp_ref_ok_o   = lamp_r[7];
   assign lamp_freeze_o   = lamp_r[8];
   assign lamp_access_o   = lamp_r[9];

   ////////////////////////////////////////////////////////////////////////////
   // Events: changes of input-ok, reference presence and input standard.

   logic       ok_d_r;
   logic       ref_d_r;
   logic [1:0] std_d_r;
   wire  [SLI_IRQ_W-1:0] ev = {(std_d_r != input_std_i),
                               (ref_d_r != ref_present),
                               (ok_d_r != ok_nxt)};

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ok_d_r  <= 1'b0;
         ref_d_r <= 1'b0;
         std_d_r <= SLI_STD_NONE;
      end
      else
      begin
         ok_d_r  <= ok_nxt;
         ref_d_r <= ref_present;
         std_d_r <= input_std_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait state, answer on the second cycle.

   wire sel     = avs_read_i | avs_write_i;
   wire do_wr   = avs_write_i & ack_r;
   wire wr_ctrl = do_wr & (avs_address_i == SLI_OFF_CTRL);
   wire wr_st   = do_wr & (avs_address_i == SLI_OFF_IRQ_ST);
   wire wr_mk   = do_wr & (avs_address_i == SLI_OFF_IRQ_MK);
   wire [1:0] wr_bank = avs_writedata_i[SLI_CTRL_BANK_LO +: 2];

   // Unmapped offsets read as zero and ignore writes.
   logic [SLI_DATA_W-1:0] rd_mux;
   always_comb
   begin
      unique case (avs_address_i)
         SLI_OFF_CTRL:   rd_mux = {29'h0, unlock_r, bank_r};
         SLI_OFF_LAMP:   rd_mux = {22'h0, lamp_r};
         SLI_OFF_IRQ_ST: rd_mux = {29'h0, irq_st_r};
         SLI_OFF_IRQ_MK: rd_mux = {29'h0, irq_mk_r};
         default:        rd_mux = 32'h0;
      endcase
   end

   assign avs_waitrequest_o = sel & ~ack_r;

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ack_r          <= 1'b0;
         avs_readdata_o <= 32'h0;
      end
      else
      begin
         ack_r <= sel & ~ack_r;
         if (sel & ~ack_r)
            avs_readdata_o <= rd_mux;
      end
   end

   // Bank code 3 is not a bank and is ignored so one lamp always stays lit.
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         bank_r   <= SLI_BANK_A;
         unlock_r <= SLI_CTRL_UNLOCK_RST;
         irq_mk_r <= SLI_IRQ_MK_RST;
      end
      else
      begin
         if (wr_ctrl)
         begin
            if (wr_bank != 2'h3)
               bank_r <= sli_bank_t'(wr_bank);
            unlock_r <= avs_writedata_i[SLI_CTRL_UNLOCK];
         end
         if (wr_mk)
            irq_mk_r <= avs_writedata_i[SLI_IRQ_W-1:0];
      end
   end

   // A new event in the clearing cycle survives the clear.
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         irq_st_r <= 3'h0;
      else
         irq_st_r <= (irq_st_r & ~(wr_st ? avs_writedata_i[SLI_IRQ_W-1:0] : 3'h0)) | ev;
   end

   assign irq_o = |(irq_st_r & irq_mk_r);

endmodule : sli_lamps
`default_nettype wire

// ==== dv/sli_lamp_view.sv ====
// Operator view of the reference lamp: counts how often it lights up.
`timescale 1ns/1ps
`default_nettype none
module sli_lamp_view
(
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   input  wire logic lamp_ref_ok_i,
   output int        rises_o
);
   logic last_r;
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         last_r  <= 1'b0;
         rises_o <= 0;
      end
      else
      begin
         last_r  <= lamp_ref_ok_i;
         rises_o <= rises_o + int'(lamp_ref_ok_i && !last_r);
      end
   end
endmodule : sli_lamp_view
`default_nettype wire

// ==== dv/sli_lamps_properties.sv ====
// Port-level checker for the status lamp block.
`timescale 1ns/1ps
`default_nettype none
module sli_lamps_properties
   import sli_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       reset_n_i,
   input wire logic       input_valid_i,
   input wire logic [1:0] input_std_i,
   input wire logic [1:0] timing_mode_i,
   input wire logic       ref_frame_present_i,
   input wire logic       ref_bnc_present_i,
   input wire logic       ref_locked_i,
   input wire logic [1:0] ref_std_i,
   input wire logic       lamp_input_ok_o,
   input wire logic       lamp_error_o,
   input wire logic       lamp_bank_a_o,
   input wire logic       lamp_bank_b_o,
   input wire logic       lamp_bank_c_o,
   input wire logic       lamp_in525_o,
   input wire logic       lamp_in625_o,
   input wire logic       lamp_ref_ok_o
);
   // The lamps lag their inputs by one edge, so checks start one edge after reset.
   logic up_r;
   logic good_r;
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         up_r   <= 1'b0;
         good_r <= 1'b0;
      end
      else
      begin
         up_r   <= 1'b1;
         good_r <= ref_locked_i && (ref_frame_present_i || ref_bnc_present_i)
                   && ref_std_i == input_std_i && input_std_i != SLI_STD_NONE;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   ////////////////////////////////////////////////////////////////////////////
   a_err_inverse: assert property (up_r |-> lamp_error_o == !lamp_input_ok_o)
      else $error("error lamp not the inverse of input lamp");
   a_ok_valid: assert property (up_r && lamp_input_ok_o |-> $past(input_valid_i))
      else $error("input lamp lit without valid input");
   a_ref_needed: assert property (up_r && lamp_input_ok_o && $past(timing_mode_i)
      inside {SLI_TM_LINE, SLI_TM_FRAME} |-> good_r)
      else $error("input lamp lit in referenced mode without good reference");
   a_bank_one: assert property ($onehot({lamp_bank_a_o, lamp_bank_b_o, lamp_bank_c_o}))
      else $error("bank lamps not one-hot");
   a_short_raster: assert property (up_r |-> lamp_in525_o == ($past(input_std_i) == SLI_STD_525))
      else $error("short raster lamp wrong");
   a_long_raster: assert property (up_r |-> lamp_in625_o == ($past(input_std_i) == SLI_STD_625))
      else $error("long raster lamp wrong");
   a_ref_off: assert property (up_r && !$past(ref_frame_present_i)
      && !$past(ref_bnc_present_i) |-> !lamp_ref_ok_o)
      else $error("reference lamp lit with no reference");
   a_ref_steady: assert property (up_r && good_r |-> lamp_ref_ok_o)
      else $error("reference lamp not steady on a matching lock");
   c_ok: cover property (lamp_input_ok_o);
   c_bank_c: cover property (lamp_bank_c_o);
   c_ref: cover property (lamp_ref_ok_o && !good_r);
endmodule : sli_lamps_properties
bind sli_lamps sli_lamps_properties u_props
(
   .clk_i(clk_i), .reset_n_i(reset_n_i), .input_valid_i(input_valid_i),
   .input_std_i(input_std_i), .timing_mode_i(timing_mode_i),
   .ref_frame_present_i(ref_frame_present_i), .ref_bnc_present_i(ref_bnc_present_i),
   .ref_locked_i(ref_locked_i), .ref_std_i(ref_std_i), .lamp_input_ok_o(lamp_input_ok_o),
   .lamp_error_o(lamp_error_o), .lamp_bank_a_o(lamp_bank_a_o), .lamp_bank_b_o(lamp_bank_b_o),
   .lamp_bank_c_o(lamp_bank_c_o), .lamp_in525_o(lamp_in525_o), .lamp_in625_o(lamp_in625_o),
   .lamp_ref_ok_o(lamp_ref_ok_o)
);
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the status lamp block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import sli_pkg::*;
;
   logic        clk_i, reset_n_i, rd, wr, wt, irq;
   logic [3:0]  adr;
   logic [31:0] wd, rdata, q;
   logic [10:0] st;
   logic [9:0]  lp;
   int          errors, n_compared, cyc, r0, rises;
   sli_lamps #(.FLASH_HALF_CYC(8)) uut
   (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wt), .input_valid_i(st[10]), .input_std_i(st[9:8]),
      .timing_mode_i(st[7:6]), .ref_frame_present_i(st[5]), .ref_bnc_present_i(st[4]),
      .ref_locked_i(st[3]), .ref_std_i(st[2:1]), .freeze_any_i(st[0]),
      .lamp_input_ok_o(lp[0]), .lamp_error_o(lp[1]), .lamp_bank_a_o(lp[2]),
      .lamp_bank_b_o(lp[3]), .lamp_bank_c_o(lp[4]), .lamp_in525_o(lp[5]),
      .lamp_in625_o(lp[6]), .lamp_ref_ok_o(lp[7]), .lamp_freeze_o(lp[8]),
      .lamp_access_o(lp[9]), .irq_o(irq)
   );
   sli_lamp_view u_view
   (.clk_i(clk_i), .reset_n_i(reset_n_i), .lamp_ref_ok_i(lp[7]), .rises_o(rises));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   // The master holds its request until the edge that samples waitrequest low.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      adr <= a;
      wd  <= d;
      rd  <= !w;
      wr  <= w;
      // Only waitrequest going low or the bench timeout may end this wait; the slave sets the pace.
      do
      begin
         @(posedge clk_i);
      end
      while (wt !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic gap();
      repeat (2) @(posedge clk_i);
      #1;
   endtask : gap
   task automatic put(input logic [10:0] v);
      @(posedge clk_i);
      st <= v;
      gap();
   endtask : put
   function automatic logic eok(input logic [10:0] v);
      logic m;
      m = v[2:1] == v[9:8] && v[9:8] != SLI_STD_NONE;
      return v[10] && (!(v[7:6] inside {SLI_TM_LINE, SLI_TM_FRAME}) || ((v[5] | v[4]) && v[3] && m));
   endfunction : eok
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         errors++;
         complete_run();
      end
   end
   initial
   begin
      {rd, wr, adr, wd, st, reset_n_i} = '0;
      q = $urandom(32'h9005);
      repeat (3) @(posedge clk_i);
      reset_n_i <= 1'b1;
      gap();
      chk("reset lamps", {lp[9], lp[4:2]}, 4'b0001);
      $display("reset test done");
      for (int b = 0; b < 4; b++)
      begin
         bus(1'b1, SLI_OFF_CTRL, b);
         gap();
         chk("bank lamps", lp[4:2], (b == 3) ? 3'b100 : 3'b001 << b);
      end
      bus(1'b1, SLI_OFF_CTRL, 32'h4);
      gap();
      bus(1'b0, SLI_OFF_LAMP, 0);
      chk("lamp reg", {q[9], q[4:2]}, 4'b1001);
      bus(1'b1, SLI_OFF_CTRL, 0);
      gap();
      chk("access lamp", lp[9], 0);
      $display("bank test done");
      for (int i = 0; i < 40; i++)
      begin
         put(i == 0 ? 11'h56a : i == 1 ? 11'h68d : i == 2 ? 11'h65a : 11'($urandom));
         chk("input ok", lp[0], eok(st));
         chk("error", lp[1], !eok(st));
         chk("in525", lp[5], st[9:8] == SLI_STD_525);
         chk("in625", lp[6], st[9:8] == SLI_STD_625);
         chk("freeze", lp[8], st[0]);
         if (!(st[5] | st[4]))
            chk("ref off", lp[7], 0);
         else if (st[2:1] == st[9:8] && st[9:8] != 0)
            chk("ref on", lp[7], st[3]);
      end
      $display("status test done");
      put(11'h52c);
      r0 = rises;
      repeat (64) @(posedge clk_i);
      chk("flashing", rises - r0 inside {[3:5]}, 1);
      put(11'h52a);
      r0 = rises;
      repeat (64) @(posedge clk_i);
      chk("steady", {lp[7], 8'(rises - r0)}, 9'h100);
      $display("flash test done");
      put(0);
      bus(1'b1, SLI_OFF_IRQ_MK, 1);
      bus(1'b1, SLI_OFF_IRQ_ST, 7);
      gap();
      chk("irq cleared", irq, 0);
      put(11'h400);
      chk("irq raised", irq, 1);
      bus(1'b0, SLI_OFF_IRQ_ST, 0);
      chk("irq status", q[2:0], 3'h1);
      bus(1'b1, SLI_OFF_IRQ_ST, 1);
      gap();
      chk("irq w1c", irq, 0);
      bus(1'b1, SLI_OFF_IRQ_MK, 0);
      put(0);
      chk("irq masked", irq, 0);
      bus(1'b0, 4'h2, 0);
      chk("unmapped", q, 0);
      $display("irq test done");
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
